// ==== verilog/sse_seq.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sse_consts.vh"

module sse_seq #(
   parameter BOARD_W = 2,
   parameter CHIP_W  = 2,
   parameter BLOCK_W = 4,
   parameter PAGE_W  = 2,
   parameter BBT_AW  = 4,
   parameter FET_AW  = 4
) (
   input  wire                               i_clk,
   input  wire                               i_srst,
   input  wire                               i_start,
   input  wire                               i_fet_rd,
   input  wire [FET_AW-1:0]                  i_fet_idx,
   input  wire                               i_mark,
   input  wire [FET_AW-1:0]                  i_mark_idx,
   input  wire                               i_blk_rd,
   input  wire [BOARD_W+CHIP_W+BLOCK_W-1:0]  i_blk_addr,
   input  wire [PAGE_W-1:0]                  i_blk_page,
   input  wire                               i_file_rd,
   input  wire                               i_fl_done,
   input  wire                               i_fl_fail,
   input  wire [7:0]                         i_fl_and,
   input  wire [7:0]                         i_fl_or,
   output reg                                o_busy,
   output reg                                o_done,
   output reg  [FET_AW:0]                    o_fail_cnt,
   output reg  [FET_AW:0]                    o_fet_cnt,
   output reg                                o_fet_valid,
   output wire [BOARD_W+CHIP_W+BLOCK_W:0]    o_fet_data,
   output reg                                o_blk_valid,
   output reg  [7:0]                         o_blk_and,
   output reg  [7:0]                         o_blk_or,
   output reg                                o_file_valid,
   output reg  [7:0]                         o_file_byte,
   output reg                                o_fl_req,
   output reg  [1:0]                         o_fl_op,
   output wire [BOARD_W-1:0]                 o_fl_board,
   output wire [CHIP_W-1:0]                  o_fl_chip,
   output wire [BLOCK_W-1:0]                 o_fl_block,
   output reg  [PAGE_W-1:0]                  o_fl_page,
   output reg  [7:0]                         o_fl_wdata
);

   localparam AW = BOARD_W + CHIP_W + BLOCK_W;
   localparam S_IDLE  = 10'h001;
   localparam S_OP    = 10'h002;
   localparam S_WAIT  = 10'h004;
   localparam S_EVAL  = 10'h008;
   localparam S_ADV   = 10'h010;
   localparam S_SCAN  = 10'h020;
   localparam S_SCMP  = 10'h040;
   localparam S_BBRD  = 10'h080;
   localparam S_BBCHK = 10'h100;
   localparam S_FAPP  = 10'h200;
   reg  [9:0]          state;
   reg  [2:0]          pass;
   reg  [AW-1:0]       cur_blk;
   reg  [BBT_AW:0]     tbl_idx;
   reg  [BBT_AW:0]     bbt_cnt;
   reg  [4:0]          tries;
   reg                 zloop;
   reg                 blkfail;
   reg                 fl_fail;
   reg  [7:0]          fl_and;
   reg  [7:0]          fl_or;
   reg  [3:0]          txt_idx;
   reg  [(1<<FET_AW)-1:0] fet_sec;
   reg                 fet_sec_q;
   reg                 bbt_we;
   reg  [AW:0]         bbt_wdata;
   reg  [BBT_AW-1:0]   bbt_waddr;
   reg                 fet_we;
   reg  [AW-1:0]       fet_wdata;
   reg  [FET_AW-1:0]   fet_waddr;
   wire [AW:0]         bbt_rdata;
   wire [AW-1:0]       fet_rdata;
   wire [95:0]         txt = `SSE_TEXT;
   wire                wr_pass = (pass == `SSE_P_WRA) || (pass == `SSE_P_WRB);
   wire [2:0]          np = pass + 3'h1;
   wire                rd_bad = (fl_and != o_fl_wdata) || (fl_or != o_fl_wdata);
   wire                pg_bad = zloop ? (fl_or != `SSE_PAT_ZERO) : (fl_and != `SSE_PAT_ONE);

   assign o_fl_board = cur_blk[AW-1 -: BOARD_W];
   assign o_fl_chip  = cur_blk[BLOCK_W +: CHIP_W];
   assign o_fl_block = cur_blk[BLOCK_W-1:0];
   assign o_fet_data = {fet_rdata, fet_sec_q};

   // Bad block table: each entry is {board, chip, block, secured flag}.
   sse_tbl #(
      .DW (AW + 1),
      .AW (BBT_AW)
   ) u_bbt (
      .i_clk   (i_clk),
      .i_we    (bbt_we),
      .i_waddr (bbt_waddr),
      .i_wdata (bbt_wdata),
      .i_raddr (tbl_idx[BBT_AW-1:0]),
      .o_rdata (bbt_rdata)
   );

   // Failed erase table; secured flags live in a register vector beside it.
   sse_tbl #(
      .DW (AW),
      .AW (FET_AW)
   ) u_fet (
      .i_clk   (i_clk),
      .i_we    (fet_we),
      .i_waddr (fet_waddr),
      .i_wdata (fet_wdata),
      .i_raddr (i_fet_idx),
      .o_rdata (fet_rdata)
   );

   always @(posedge i_clk) begin
      if (i_srst) begin
         state        <= S_IDLE;
         cur_blk      <= {AW{1'b0}};
         bbt_cnt      <= {(BBT_AW+1){1'b0}};
         txt_idx      <= 4'h0;
         fet_sec      <= {(1<<FET_AW){1'b0}};
         fet_sec_q    <= 1'b0;
         bbt_we       <= 1'b0;
         fet_we       <= 1'b0;
         o_busy       <= 1'b0;
         o_done       <= 1'b0;
         o_fail_cnt   <= {(FET_AW+1){1'b0}};
         o_fet_cnt    <= {(FET_AW+1){1'b0}};
         o_fet_valid  <= 1'b0;
         o_blk_valid  <= 1'b0;
         o_blk_and    <= 8'h00;
         o_blk_or     <= 8'h00;
         o_file_valid <= 1'b0;
         o_file_byte  <= 8'h00;
         o_fl_req     <= 1'b0;
         o_fl_op      <= `SSE_OP_ERASE;
         o_fl_page    <= {PAGE_W{1'b0}};
         o_fl_wdata   <= 8'h00;
      end else begin
         o_fl_req     <= 1'b0;
         o_done       <= 1'b0;
         o_fet_valid  <= 1'b0;
         o_blk_valid  <= 1'b0;
         o_file_valid <= 1'b0;
         bbt_we       <= 1'b0;
         fet_we       <= 1'b0;
         case (state)
            S_IDLE: begin
               if (i_start) begin
                  pass       <= `SSE_P_ER1;
                  cur_blk    <= {AW{1'b0}};
                  o_fl_page  <= {PAGE_W{1'b0}};
                  o_fl_op    <= `SSE_OP_ERASE;
                  o_fet_cnt  <= {(FET_AW+1){1'b0}};
                  o_fail_cnt <= {(FET_AW+1){1'b0}};
                  fet_sec    <= {(1<<FET_AW){1'b0}};
                  o_busy     <= 1'b1;
                  state      <= S_OP;
               end else if (i_fet_rd) begin
                  o_fet_valid <= 1'b1;
                  fet_sec_q   <= fet_sec[i_fet_idx];
               end else if (i_mark) begin
                  if (({1'b0, i_mark_idx} < o_fet_cnt) && !fet_sec[i_mark_idx]) begin
                     fet_sec[i_mark_idx] <= 1'b1;
                     o_fail_cnt          <= o_fail_cnt - 1'b1;
                  end
               end else if (i_blk_rd) begin
                  pass      <= `SSE_P_USER;
                  cur_blk   <= i_blk_addr;
                  o_fl_page <= i_blk_page;
                  o_fl_op   <= `SSE_OP_READ;
                  o_busy    <= 1'b1;
                  state     <= S_OP;
               end else if (i_file_rd) begin
                  o_file_valid <= 1'b1;
                  if (o_fail_cnt == {(FET_AW+1){1'b0}}) begin
                     o_file_byte <= txt[{`SSE_TEXT_END - txt_idx, 3'h0} +: 8];
                     txt_idx     <= (txt_idx == `SSE_TEXT_END) ? 4'h0 : txt_idx + 4'h1;
                  end else begin
                     o_file_byte <= 8'h00;
                  end
               end
            end
            S_OP: begin
               o_fl_req <= 1'b1;
               state    <= S_WAIT;
            end
            S_WAIT: begin
               if (i_fl_done) begin
                  fl_fail <= i_fl_fail;
                  fl_and  <= i_fl_and;
                  fl_or   <= i_fl_or;
                  state   <= S_EVAL;
               end
            end
            S_EVAL: begin
               tbl_idx <= (pass == `SSE_P_BAD) ? tbl_idx : {(BBT_AW+1){1'b0}};
               if (pass == `SSE_P_USER) begin
                  o_blk_valid <= 1'b1;
                  o_blk_and   <= fl_and;
                  o_blk_or    <= fl_or;
                  o_busy      <= 1'b0;
                  state       <= S_IDLE;
               end else if (pass == `SSE_P_BAD) begin
                  if (o_fl_op != `SSE_OP_READ) begin
                     o_fl_op <= `SSE_OP_READ;
                     state   <= S_OP;
                  end else if (pg_bad && (tries < `SSE_TRIES - 5'h01)) begin
                     tries   <= tries + 5'h01;
                     o_fl_op <= zloop ? `SSE_OP_PROG : `SSE_OP_ERASE;
                     state   <= S_OP;
                  end else begin
                     blkfail <= blkfail | pg_bad;
                     tries   <= 5'h00;
                     if (&o_fl_page) begin
                        o_fl_page <= {PAGE_W{1'b0}};
                        if (zloop) begin
                           zloop      <= 1'b0;
                           o_fl_op    <= `SSE_OP_ERASE;
                           o_fl_wdata <= `SSE_PAT_ONE;
                           state      <= S_OP;
                        end else begin
                           state <= S_FAPP;
                        end
                     end else begin
                        o_fl_page <= o_fl_page + 1'b1;
                        o_fl_op   <= zloop ? `SSE_OP_PROG : `SSE_OP_ERASE;
                        state     <= S_OP;
                     end
                  end
               end else if (o_fl_op == `SSE_OP_PROG) begin
                  if (fl_fail) begin
                     state <= S_SCAN;
                  end else begin
                     o_fl_op <= `SSE_OP_READ;
                     state   <= S_OP;
                  end
               end else if (o_fl_op == `SSE_OP_READ) begin
                  state <= rd_bad ? S_SCAN : S_ADV;
               end else begin
                  state <= fl_fail ? S_SCAN : S_ADV;
               end
            end
            S_ADV: begin
               if (!wr_pass || (&o_fl_page)) begin
                  o_fl_page <= {PAGE_W{1'b0}};
                  if (&cur_blk) begin
                     cur_blk <= {AW{1'b0}};
                     if (pass == `SSE_P_ER3) begin
                        pass    <= `SSE_P_BAD;
                        tbl_idx <= {(BBT_AW+1){1'b0}};
                        state   <= S_BBRD;
                     end else begin
                        pass       <= np;
                        o_fl_op    <= np[0] ? `SSE_OP_PROG : `SSE_OP_ERASE;
                        o_fl_wdata <= (np == `SSE_P_WRA) ? `SSE_PAT_A : `SSE_PAT_B;
                        state      <= S_OP;
                     end
                  end else begin
                     cur_blk <= cur_blk + 1'b1;
                     o_fl_op <= wr_pass ? `SSE_OP_PROG : `SSE_OP_ERASE;
                     state   <= S_OP;
                  end
               end else begin
                  o_fl_page <= o_fl_page + 1'b1;
                  o_fl_op   <= `SSE_OP_PROG;
                  state     <= S_OP;
               end
            end
            S_SCAN: begin
               if (tbl_idx == bbt_cnt) begin
                  if (!bbt_cnt[BBT_AW]) begin
                     bbt_we    <= 1'b1;
                     bbt_waddr <= bbt_cnt[BBT_AW-1:0];
                     bbt_wdata <= {cur_blk, 1'b0};
                     bbt_cnt   <= bbt_cnt + 1'b1;
                  end
                  state <= S_ADV;
               end else begin
                  state <= S_SCMP;
               end
            end
            S_SCMP: begin
               if (bbt_rdata[AW:1] == cur_blk) begin
                  state <= S_ADV;
               end else begin
                  tbl_idx <= tbl_idx + 1'b1;
                  state   <= S_SCAN;
               end
            end
            S_BBRD: begin
               if (tbl_idx == bbt_cnt) begin
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  state  <= S_IDLE;
               end else begin
                  state <= S_BBCHK;
               end
            end
            S_BBCHK: begin
               if (bbt_rdata[0]) begin
                  tbl_idx <= tbl_idx + 1'b1;
                  state   <= S_BBRD;
               end else begin
                  cur_blk    <= bbt_rdata[AW:1];
                  o_fl_page  <= {PAGE_W{1'b0}};
                  tries      <= 5'h00;
                  zloop      <= 1'b1;
                  blkfail    <= 1'b0;
                  o_fl_op    <= `SSE_OP_PROG;
                  o_fl_wdata <= `SSE_PAT_ZERO;
                  state      <= S_OP;
               end
            end
            S_FAPP: begin
               if (blkfail && !o_fet_cnt[FET_AW]) begin
                  fet_we     <= 1'b1;
                  fet_waddr  <= o_fet_cnt[FET_AW-1:0];
                  fet_wdata  <= cur_blk;
                  o_fet_cnt  <= o_fet_cnt + 1'b1;
                  o_fail_cnt <= o_fail_cnt + 1'b1;
               end
               tbl_idx <= tbl_idx + 1'b1;
               state   <= S_BBRD;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== inc/sse_consts.vh ====
// How it works
// - Every block is visited in each of passes one to five.
// - Pass one erases all; erase failure marks bad.
// - Pass two writes 0x55, reads back each location.
// - Write failure or readback mismatch marks block bad.
// - Pass three erases all; erase failure marks bad.
// - Pass four writes 0xaa, reads back each location.
// - Pass five erases all; erase failure marks bad.
// - New bad block appended, secured flag clear.
// - Blocks absent from bad table count as erased.
// - Bad entries already flagged secured are skipped.
// - Unsecured bad entries get zeros then ones loop.
// - Zeros loop rewrites failing page, 16 attempts max.
// - Remaining unexpected ones record block as failed.
// - Ones loop re-erases failing block, 16 attempts max.
// - Remaining unexpected zeros record block as failed.
// - Report count of unsecured failed-table entries.
// - User command reads failed erase table.
// - User reads block data and marks entries secured.
// - Empty failure count makes file text repeat.
`ifndef SSE_CONSTS_VH
`define SSE_CONSTS_VH

`define SSE_OP_ERASE 2'h0
`define SSE_OP_PROG  2'h1
`define SSE_OP_READ  2'h2

`define SSE_PAT_A    8'h55
`define SSE_PAT_B    8'haa
`define SSE_PAT_ZERO 8'h00
`define SSE_PAT_ONE  8'hff

`define SSE_P_ER1    3'h0
`define SSE_P_WRA    3'h1
`define SSE_P_ER2    3'h2
`define SSE_P_WRB    3'h3
`define SSE_P_ER3    3'h4
`define SSE_P_BAD    3'h5
`define SSE_P_USER   3'h6

`define SSE_TRIES    5'h10

`define SSE_TEXT     96'h536563757265204572617365
`define SSE_TEXT_END 4'hb

`endif

// ==== verilog/sse_tbl.v ====
`timescale 1ns/10ps
`default_nettype none

module sse_tbl #(
   parameter DW = 9,
   parameter AW = 4
) (
   input  wire          i_clk,
   input  wire          i_we,
   input  wire [AW-1:0] i_waddr,
   input  wire [DW-1:0] i_wdata,
   input  wire [AW-1:0] i_raddr,
   output reg  [DW-1:0] o_rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule

`default_nettype wire

// ==== testbench/sse_seq_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sse_consts.vh"

module sse_seq_chk #(
   parameter BLOCK_W = 4,
   parameter PAGE_W  = 2,
   parameter FET_AW  = 4
) (
   input wire logic               i_clk,
   input wire logic               i_srst,
   input wire logic               i_start,
   input wire logic               i_fet_rd,
   input wire logic               i_mark,
   input wire logic [FET_AW-1:0]  i_mark_idx,
   input wire logic               i_blk_rd,
   input wire logic               i_file_rd,
   input wire logic               i_fl_done,
   input wire logic               o_busy,
   input wire logic               o_done,
   input wire logic [FET_AW:0]    o_fail_cnt,
   input wire logic [FET_AW:0]    o_fet_cnt,
   input wire logic               o_fet_valid,
   input wire logic               o_file_valid,
   input wire logic [7:0]         o_file_byte,
   input wire logic               o_fl_req,
   input wire logic [1:0]         o_fl_op,
   input wire logic [BLOCK_W-1:0] o_fl_block,
   input wire logic [PAGE_W-1:0]  o_fl_page,
   input wire logic [7:0]         o_fl_wdata
);
   logic pend;

   // Tracks one outstanding flash operation.
   always @(posedge i_clk) begin
      if (i_srst)
         pend <= 1'b0;
      else if (o_fl_req)
         pend <= 1'b1;
      else if (i_fl_done)
         pend <= 1'b0;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_kick;
      i_start && !o_busy;
   endsequence
   sequence s_first_erase;
      o_busy && o_fl_op == `SSE_OP_ERASE && o_fl_block == '0;
   endsequence

   chk_run_begins: assert property (s_kick |=> s_first_erase)
      else $error("run did not open with an erase of block zero");
   chk_one_op: assert property (o_fl_req |-> !pend)
      else $error("second flash request while one is outstanding");
   chk_req_spacing: assert property (i_fl_done && pend |-> !o_fl_req ##1 !o_fl_req)
      else $error("flash request too soon after completion");
   chk_target_holds: assert property ((o_fl_req || pend) |-> $stable(o_fl_op) &&
      $stable(o_fl_block) && $stable(o_fl_page) && $stable(o_fl_wdata))
      else $error("flash target changed during an operation");
   chk_prog_pattern: assert property (o_fl_req && o_fl_op == `SSE_OP_PROG |->
      o_fl_wdata inside {8'h55, 8'haa, 8'h00})
      else $error("program with an unexpected pattern");
   chk_ops_busy: assert property (o_fl_req |-> o_busy)
      else $error("flash request while idle");
   chk_done_ends: assert property (o_done |-> !o_busy && $past(o_busy))
      else $error("done pulse without busy falling");
   chk_fet_answer: assert property (i_fet_rd && !o_busy && !i_start |=> o_fet_valid)
      else $error("failed table read not answered");
   chk_file_answer: assert property (i_file_rd && !o_busy && !i_start && !i_fet_rd
      && !i_mark && !i_blk_rd |=> o_file_valid)
      else $error("file byte read not answered");
   chk_file_blank: assert property (o_file_valid && o_fail_cnt != '0 |-> o_file_byte == 8'h00)
      else $error("file text given while failures remain");
   chk_fail_bound: assert property (o_fail_cnt <= o_fet_cnt)
      else $error("failure count above table count");
   chk_mark_range: assert property (i_mark && !o_busy && !i_start && !i_fet_rd &&
      i_mark_idx >= o_fet_cnt |=> $stable(o_fail_cnt))
      else $error("mark beyond table changed the count");
endmodule

bind sse_seq sse_seq_chk #(.BLOCK_W(BLOCK_W), .PAGE_W(PAGE_W), .FET_AW(FET_AW)) u_chk (.*);
`default_nettype wire

// ==== testbench/sse_flash_mdl.sv ====
`timescale 1ns/10ps
`default_nettype none

module sse_flash_mdl (
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   input  wire logic       i_start,
   input  wire logic       i_req,
   input  wire logic [1:0] i_op,
   input  wire logic [3:0] i_loc,
   input  wire logic [7:0] i_wdata,
   output var  logic       o_done,
   output var  logic       o_fail,
   output var  logic [7:0] o_and,
   output var  logic [7:0] o_or
);
   logic [7:0]  mem [0:15];
   logic [7:0]  rd;
   logic        pend;
   logic        slow;
   logic [1:0]  dly;
   logic [15:0] n_erase, zprog, e_at55, e_ataa, e_at00;

   // Location 11 has a bit stuck high, location 12 a bit stuck low.
   assign rd = (mem[i_loc] | (i_loc == 4'hb ? 8'h01 : 8'h00)) & (i_loc == 4'hc ? 8'h7f : 8'hff);

   // Answers alternate between prompt and slow; read lines change every idle cycle.
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_and <= ~o_and;
      o_or <= ~o_or;
      if (i_start) begin
         {n_erase, zprog} <= 32'h0;
         {e_at55, e_ataa, e_at00} <= {48{1'b1}};
      end
      if (i_srst) begin
         pend <= 1'b0;
         slow <= 1'b0;
         o_and <= 8'h00;
         o_or <= 8'hff;
      end else if (!pend) begin
         pend <= i_req;
         dly <= slow ? 2'h2 : 2'h0;
         slow <= slow ^ i_req;
      end else if (dly != 2'h0) begin
         dly <= dly - 2'h1;
      end else begin
         pend <= 1'b0;
         o_done <= 1'b1;
         if (i_op == 2'h0) begin
            mem[{i_loc[3:1], 1'b0}] <= 8'hff;
            mem[{i_loc[3:1], 1'b1}] <= 8'hff;
            o_fail <= i_loc[3:1] == 3'h2 && n_erase < 16'h8;
            n_erase <= n_erase + 16'h1;
         end else if (i_op == 2'h1) begin
            mem[i_loc] <= mem[i_loc] & i_wdata;
            if (i_wdata == 8'h55 && e_at55 == 16'hffff) e_at55 <= n_erase;
            if (i_wdata == 8'haa && e_ataa == 16'hffff) e_ataa <= n_erase;
            if (i_wdata == 8'h00 && e_at00 == 16'hffff) e_at00 <= n_erase;
            if (i_wdata == 8'h00 && i_loc == 4'hb) zprog <= zprog + 16'h1;
         end else begin
            o_and <= rd;
            o_or <= rd;
         end
      end
   end
endmodule

`default_nettype wire

// ==== testbench/secure_erase_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module secure_erase_sequencer_tb;
   localparam logic [95:0] TXT = "Secure Erase";
   logic       i_clk = 1'b0;
   logic       i_srst, i_start, i_fet_rd, i_mark, i_blk_rd, i_file_rd;
   logic       i_fl_done, i_fl_fail, o_busy, o_done, o_fet_valid, o_blk_valid;
   logic       o_file_valid, o_fl_req, o_fl_board, o_fl_chip, o_fl_block, o_fl_page;
   logic [3:0] i_fet_idx, i_mark_idx, o_fet_data;
   logic [2:0] i_blk_addr;
   logic       i_blk_page;
   logic [7:0] i_fl_and, i_fl_or, o_blk_and, o_blk_or, o_file_byte, o_fl_wdata;
   logic [4:0] o_fail_cnt, o_fet_cnt;
   logic [1:0] o_fl_op;
   int         fails = 0;
   int         total_checks = 0;
   logic [3:0] pulses;

   sse_seq #(.BOARD_W(1), .CHIP_W(1), .BLOCK_W(1), .PAGE_W(1), .FET_AW(4)) DUT (.*);

   sse_flash_mdl MDL (.i_clk(i_clk), .i_srst(i_srst), .i_start(i_start), .i_req(o_fl_req),
      .i_op(o_fl_op), .i_loc({o_fl_board, o_fl_chip, o_fl_block, o_fl_page}),
      .i_wdata(o_fl_wdata), .o_done(i_fl_done), .o_fail(i_fl_fail), .o_and(i_fl_and),
      .o_or(i_fl_or));

   always #2.5 i_clk = ~i_clk;

   task automatic end_sim();
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Pulses one command, then waits for the block to be idle again.
   task automatic cmd(input logic [4:0] w, input logic [3:0] ix, input logic [3:0] ad);
      int n;
      @(posedge i_clk);
      {i_start, i_blk_rd, i_file_rd, i_mark, i_fet_rd} <= w;
      i_fet_idx <= ix;
      i_mark_idx <= ix;
      {i_blk_addr, i_blk_page} <= ad;
      @(posedge i_clk);
      {i_start, i_blk_rd, i_file_rd, i_mark, i_fet_rd} <= 5'h0;
      pulses = 4'h0;
      for (n = 0; n < 20000; n++) begin
         @(negedge i_clk);
         pulses |= {o_done, o_blk_valid, o_file_valid, o_fet_valid};
         if (n > 2 && o_busy === 1'b0) break;
      end
      if (n == 20000) begin
         fails++;
         end_sim();
      end
   endtask

   task automatic t_run();
      cmd(5'h10, 4'h0, 4'h0);
      check(16'(pulses), 16'h8);
      check(16'(o_fail_cnt), 16'h2);
      check(16'(o_fet_cnt), 16'h2);
      check(MDL.zprog, 16'h10);
      check(MDL.e_at55, 16'h8);
      check(MDL.e_ataa, 16'h10);
      check(MDL.e_at00, 16'h18);
   endtask

   task automatic t_table();
      cmd(5'h01, 4'h0, 4'h0);
      check(16'(o_fet_data), 16'ha);
      check(16'(pulses), 16'h1);
      cmd(5'h01, 4'h1, 4'h0);
      check(16'(o_fet_data), 16'hc);
      cmd(5'h04, 4'h0, 4'h0);
      check(16'(o_file_byte), 16'h0);
      check(16'(pulses), 16'h2);
   endtask

   task automatic t_mark();
      cmd(5'h02, 4'h0, 4'h0);
      check(16'(pulses), 16'h0);
      check(16'(o_fail_cnt), 16'h1);
      cmd(5'h02, 4'h0, 4'h0);
      check(16'(o_fail_cnt), 16'h1);
      cmd(5'h02, 4'h7, 4'h0);
      check(16'(o_fail_cnt), 16'h1);
      cmd(5'h01, 4'h0, 4'h0);
      check(16'(o_fet_data), 16'hb);
      cmd(5'h02, 4'h1, 4'h0);
      check(16'(o_fail_cnt), 16'h0);
   endtask

   task automatic t_file();
      for (int j = 0; j < 24; j++) begin
         cmd(5'h04, 4'h0, 4'h0);
         check(16'(o_file_byte), 16'(TXT[95-8*(j%12) -: 8]));
      end
   endtask

   task automatic t_blk();
      cmd(5'h08, 4'h0, 4'hc);
      check({o_blk_and, o_blk_or}, 16'h7f7f);
      check(16'(pulses), 16'h4);
      cmd(5'h08, 4'h0, 4'h7);
      check({o_blk_and, o_blk_or}, 16'hffff);
   endtask

   initial begin
      {i_start, i_blk_rd, i_file_rd, i_mark, i_fet_rd} = 5'h0;
      {i_fet_idx, i_mark_idx, i_blk_addr, i_blk_page} = 12'h0;
      i_srst = 1'b1;
      repeat (20) @(posedge i_clk);
      i_srst <= 1'b0;
      t_run();
      t_run();
      t_table();
      t_mark();
      t_file();
      t_blk();
      end_sim();
   end
endmodule

`default_nettype wire
